// *** rtl/pmt_regs.svh ***
`ifndef PMT_REGS_SVH
`define PMT_REGS_SVH

// Register byte offsets on the APB bus.
`define PMT_OFS_PTR 12'h000
`define PMT_OFS_CMD 12'h004
`define PMT_OFS_DATA 12'h008
`define PMT_OFS_STAT 12'h00c

// Command register fields.
`define PMT_CMD_OP 1:0
`define PMT_CMD_HI 2
`define PMT_CMD_INC 3
`define PMT_CMD_BYTE 15:8
`define PMT_CMD_W 16

// Status register fields.
`define PMT_ST_BUSY 0
`define PMT_ST_LONG 1
`define PMT_ST_ABORT 2
`define PMT_ST_EXT 3
`define PMT_ST_VPP 4

// Reset values.
`define PMT_PTR_RST 16'h0000
`define PMT_WORD_RST 16'h0000
`define PMT_BYTE_RST 8'h00

// Q phases of one instruction cycle, four clocks long.
`define PMT_Q_ALE 2'h0
`define PMT_Q_DATA 2'h1
`define PMT_Q_STROBE 2'h2
`define PMT_Q_LAST 2'h3

`endif

// *** rtl/pmt_pkg.sv ***
package pmt_pkg;

  typedef enum logic [1:0] {
    latch_write_op,
    latch_read_op,
    table_write_op,
    table_read_op
  } pmt_op_t;

  typedef enum logic [1:0] {
    st_idle,
    st_cyc1,
    st_cyc2,
    st_long
  } pmt_state_t;

endpackage

// *** rtl/pmt_latch.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pmt_regs.svh"

// Sixteen-bit holding latch, loaded a byte at a time or as a whole word.
module pmt_latch (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic byte_we,
  input wire logic byte_hi,
  input wire logic [7:0] byte_in,
  input wire logic word_we,
  input wire logic [15:0] word_in,
  output logic [15:0] word
);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word <= `PMT_WORD_RST;
    end else if (word_we) begin
      word <= word_in;
    end else if (byte_we && byte_hi) begin
      word[15:8] <= byte_in;
    end else if (byte_we) begin
      word[7:0] <= byte_in;
    end
  end

endmodule
`default_nettype wire

// *** rtl/pmt_table_access.sv ***
// Functional notes
// - Sixteen-bit program words move through a 16-bit latch as two byte steps.
// - Latch write and table write carry data bytes into program memory.
// - Latch read and table read carry a program word out as bytes.
// - External memory is used only in the external program modes.
// - Internal table write starts a long write that halts the core.
// - Only reset or an enabled, flagged source ends a long write.
// - Global disable bit only decides whether the core vectors afterwards.
// - Ending by pin or timer source clears the top-priority such flag.
// - Ending by a peripheral source leaves its flag set.
// - With global disable set, timer or pin source ends without vectoring, clears.
// - A source lacking enable or flag never affects a long write.
// - Pending interrupt at table write start makes it a no-op, clears flag.
// - Without programming voltage, internal write is two cycles, memory unchanged.
// - External table write takes two cycles, data written in the second.
// - Increment operand advances the 16-bit pointer after the access.
// - Table read returns the latch byte first, then reloads the latch.
// - Table read is two cycles, second a data read on the bus.
// - External accesses keep separate read and write latches.
// - The pointer is two bytes forming a 16-bit program address.
// - The latch is reachable only through the table and latch operations.
`timescale 1ns/1ps
`default_nettype none
`include "pmt_regs.svh"

module pmt_table_access (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_mode,
  input wire logic clear_and_prog_voltage_pin,
  input wire logic global_interrupt_disable,
  input wire logic [3:0] irq_enable,
  input wire logic [3:0] irq_flag,
  output logic [2:0] irq_flag_clear,
  output logic vector_req,
  output logic core_halt,
  output logic [15:0] prog_addr,
  output logic [15:0] prog_wdata,
  output logic prog_write,
  output logic prog_read,
  input wire logic [15:0] prog_rdata,
  output logic [15:0] muxed_addr_data_bus_out,
  input wire logic [15:0] muxed_addr_data_bus_in,
  output logic muxed_addr_data_bus_oe_n,
  output logic bus_ale,
  output logic bus_oe_n,
  output logic bus_wr_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  pmt_pkg::pmt_state_t state;
  pmt_pkg::pmt_op_t op;
  logic [1:0] q;
  logic op_hi;
  logic op_inc;
  logic op_ext;
  logic [7:0] op_byte;
  logic [7:0] result;
  logic [`PMT_CMD_W-1:0] last_cmd;
  logic aborted;
  logic [15:0] table_pointer;
  logic ptr_inc;
  logic wl_we;
  logic rl_load;
  logic [15:0] rl_src;
  logic [15:0] wr_word;
  logic [15:0] rd_word;
  logic [7:0] rd_byte;
  logic vpp_s1;
  logic vpp_s2;
  logic vpp_s3;
  logic vpp_ok;
  logic apb_wr;
  logic cmd_go;
  logic term_core;
  logic term_any;
  logic [2:0] core_prio;

  // Pin and timer sources (bits 0 to 2, bit 0 highest); bit 3 is peripheral.
  assign term_core = |(irq_enable[2:0] & irq_flag[2:0]);
  assign term_any = term_core | (irq_enable[3] & irq_flag[3]);
  assign core_prio[0] = irq_enable[0] & irq_flag[0];
  assign core_prio[1] = irq_enable[1] & irq_flag[1] & ~core_prio[0];
  assign core_prio[2] = irq_enable[2] & irq_flag[2] & ~|core_prio[1:0];

  assign apb_wr = psel && penable && pready && pwrite;
  assign cmd_go = apb_wr && (paddr == `PMT_OFS_CMD) &&
                  (state == pmt_pkg::st_idle);
  assign rd_byte = op_hi ? rd_word[15:8] : rd_word[7:0];
  assign prog_wdata = wr_word;

  ////////////////////////////////////////////////////////////////////////////
  // Programming voltage pin synchroniser.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vpp_s1 <= 1'b0;
      vpp_s2 <= 1'b0;
      vpp_s3 <= 1'b0;
      vpp_ok <= 1'b0;
    end else begin
      vpp_s1 <= clear_and_prog_voltage_pin;
      vpp_s2 <= vpp_s1;
      vpp_s3 <= vpp_s2;
      if (vpp_s2 == vpp_s3) begin
        vpp_ok <= vpp_s3;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave with one wait state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      if (paddr == `PMT_OFS_PTR) begin
        prdata[15:0] <= table_pointer;
      end else if (paddr == `PMT_OFS_CMD) begin
        prdata[`PMT_CMD_W-1:0] <= last_cmd;
      end else if (paddr == `PMT_OFS_DATA) begin
        prdata[7:0] <= result;
      end else if (paddr == `PMT_OFS_STAT) begin
        prdata[`PMT_ST_BUSY] <= (state != pmt_pkg::st_idle);
        prdata[`PMT_ST_LONG] <= core_halt;
        prdata[`PMT_ST_ABORT] <= aborted;
        prdata[`PMT_ST_EXT] <= ext_mode;
        prdata[`PMT_ST_VPP] <= vpp_ok;
      end else begin
        pslverr <= 1'b1;
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_cmd <= '0;
    end else if (cmd_go) begin
      last_cmd <= pwdata[`PMT_CMD_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Table pointer, written only while idle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      table_pointer <= `PMT_PTR_RST;
    end else if (ptr_inc) begin
      table_pointer <= table_pointer + 16'h0001;
    end else if (apb_wr && (paddr == `PMT_OFS_PTR) &&
                 (state == pmt_pkg::st_idle)) begin
      table_pointer <= pwdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Holding latches; they are shared for internal memory only.
  pmt_latch u_write_latch (
    .pclk(pclk),
    .presetn(presetn),
    .byte_we(wl_we),
    .byte_hi(op_hi),
    .byte_in(op_byte),
    .word_we(rl_load && !op_ext),
    .word_in(rl_src),
    .word(wr_word)
  );

  pmt_latch u_read_latch (
    .pclk(pclk),
    .presetn(presetn),
    .byte_we(wl_we && !op_ext),
    .byte_hi(op_hi),
    .byte_in(op_byte),
    .word_we(rl_load),
    .word_in(rl_src),
    .word(rd_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: each instruction cycle is four clocks, q counts the phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= pmt_pkg::st_idle;
      op <= pmt_pkg::latch_write_op;
      q <= `PMT_Q_ALE;
      op_hi <= 1'b0;
      op_inc <= 1'b0;
      op_ext <= 1'b0;
      op_byte <= `PMT_BYTE_RST;
      result <= `PMT_BYTE_RST;
      aborted <= 1'b0;
      wl_we <= 1'b0;
      rl_load <= 1'b0;
      rl_src <= `PMT_WORD_RST;
      ptr_inc <= 1'b0;
      irq_flag_clear <= 3'h0;
      vector_req <= 1'b0;
      core_halt <= 1'b0;
      prog_write <= 1'b0;
      prog_read <= 1'b0;
      prog_addr <= `PMT_PTR_RST;
      muxed_addr_data_bus_out <= `PMT_WORD_RST;
      muxed_addr_data_bus_oe_n <= 1'b1;
      bus_ale <= 1'b0;
      bus_oe_n <= 1'b1;
      bus_wr_n <= 1'b1;
    end else begin
      wl_we <= 1'b0;
      rl_load <= 1'b0;
      ptr_inc <= 1'b0;
      irq_flag_clear <= 3'h0;
      vector_req <= 1'b0;
      case (state)
        pmt_pkg::st_idle: begin
          if (cmd_go) begin
            state <= pmt_pkg::st_cyc1;
            q <= `PMT_Q_ALE;
            op <= pmt_pkg::pmt_op_t'(pwdata[`PMT_CMD_OP]);
            op_hi <= pwdata[`PMT_CMD_HI];
            op_inc <= pwdata[`PMT_CMD_INC];
            op_byte <= pwdata[`PMT_CMD_BYTE];
            op_ext <= ext_mode;
            aborted <= 1'b0;
          end
        end
        pmt_pkg::st_cyc1: begin
          q <= q + 2'h1;
          if (q == `PMT_Q_ALE) begin
            if (op == pmt_pkg::table_write_op && term_any) begin
              irq_flag_clear <= core_prio;
              aborted <= 1'b1;
            end else if (op == pmt_pkg::table_write_op ||
                         op == pmt_pkg::latch_write_op) begin
              wl_we <= 1'b1;
            end
          end
          if (q == `PMT_Q_LAST) begin
            case (op)
              pmt_pkg::latch_write_op: begin
                state <= pmt_pkg::st_idle;
              end
              pmt_pkg::latch_read_op: begin
                result <= rd_byte;
                state <= pmt_pkg::st_idle;
              end
              pmt_pkg::table_read_op: begin
                result <= rd_byte;
                state <= pmt_pkg::st_cyc2;
              end
              default: begin
                if (aborted) begin
                  state <= pmt_pkg::st_idle;
                end else if (!op_ext && vpp_ok) begin
                  state <= pmt_pkg::st_long;
                  core_halt <= 1'b1;
                  prog_write <= 1'b1;
                  prog_addr <= table_pointer;
                end else begin
                  state <= pmt_pkg::st_cyc2;
                end
              end
            endcase
          end
        end
        pmt_pkg::st_cyc2: begin
          q <= q + 2'h1;
          case (q)
            `PMT_Q_ALE: begin
              if (op_ext) begin
                bus_ale <= 1'b1;
                muxed_addr_data_bus_out <= table_pointer;
                muxed_addr_data_bus_oe_n <= 1'b0;
              end else if (op == pmt_pkg::table_read_op) begin
                prog_read <= 1'b1;
                prog_addr <= table_pointer;
              end
            end
            `PMT_Q_DATA: begin
              bus_ale <= 1'b0;
              prog_read <= 1'b0;
              if (op_ext && op == pmt_pkg::table_read_op) begin
                muxed_addr_data_bus_oe_n <= 1'b1;
                bus_oe_n <= 1'b0;
              end else if (op_ext) begin
                muxed_addr_data_bus_out <= wr_word;
              end
            end
            `PMT_Q_STROBE: begin
              if (op_ext && op == pmt_pkg::table_write_op) begin
                bus_wr_n <= 1'b0;
              end else if (!op_ext && op == pmt_pkg::table_read_op) begin
                rl_load <= 1'b1;
                rl_src <= prog_rdata;
              end
            end
            default: begin
              if (op_ext && op == pmt_pkg::table_read_op) begin
                rl_load <= 1'b1;
                rl_src <= muxed_addr_data_bus_in;
              end
              bus_oe_n <= 1'b1;
              bus_wr_n <= 1'b1;
              muxed_addr_data_bus_oe_n <= 1'b1;
              ptr_inc <= op_inc;
              state <= pmt_pkg::st_idle;
            end
          endcase
        end
        default: begin
          if (term_any) begin
            core_halt <= 1'b0;
            prog_write <= 1'b0;
            irq_flag_clear <= core_prio;
            vector_req <= !global_interrupt_disable;
            ptr_inc <= op_inc;
            state <= pmt_pkg::st_idle;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_halt_means_write: assert property (
    core_halt |-> prog_write && !op_ext && state == pmt_pkg::st_long)
    else $error("halt without an internal long write");

  a_term_ends_halt: assert property (
    core_halt && term_any |=> !core_halt && state == pmt_pkg::st_idle)
    else $error("long write not ended by enabled source");

  a_no_src_holds: assert property (
    core_halt && !term_any |=> core_halt)
    else $error("long write ended without a source");

  a_vector_choice: assert property (
    core_halt && term_any |=> vector_req == !$past(global_interrupt_disable))
    else $error("vectoring does not follow global disable");

  a_core_flag_clear: assert property (
    core_halt && term_core |=> irq_flag_clear == $past(core_prio) &&
    $onehot(irq_flag_clear))
    else $error("wrong flag cleared on termination");

  a_periph_flag_kept: assert property (
    core_halt && term_any && !term_core |=> irq_flag_clear == 3'h0)
    else $error("peripheral flag cleared");

  a_pending_abort: assert property (
    state == pmt_pkg::st_cyc1 && q == `PMT_Q_ALE &&
    op == pmt_pkg::table_write_op && term_any
    |=> irq_flag_clear == $past(core_prio) ##3
    state == pmt_pkg::st_idle && !prog_write)
    else $error("pending table write not aborted");

  a_no_vpp_short: assert property (
    state == pmt_pkg::st_cyc1 && q == `PMT_Q_LAST && !aborted && !op_ext &&
    op == pmt_pkg::table_write_op && !vpp_ok
    |=> !prog_write [*4] ##1 state == pmt_pkg::st_idle)
    else $error("write without voltage not two cycles");

  a_ext_no_prog: assert property (
    op_ext |-> !prog_write && !prog_read)
    else $error("internal memory touched in external mode");

  a_wr_strobe_cyc2: assert property (
    $fell(bus_wr_n) |-> state == pmt_pkg::st_cyc2 && op_ext &&
    muxed_addr_data_bus_out == wr_word ##1 $rose(bus_wr_n))
    else $error("external write strobe misplaced");

  a_read_two_cycles: assert property (
    $rose(state == pmt_pkg::st_cyc1) && op == pmt_pkg::table_read_op
    |-> ##4 state == pmt_pkg::st_cyc2 ##4 state == pmt_pkg::st_idle)
    else $error("table read not two instruction cycles");

  a_ptr_increment: assert property (
    state == pmt_pkg::st_cyc2 && q == `PMT_Q_LAST
    |=> ##1 table_pointer == $past(table_pointer, 2) + 16'(op_inc))
    else $error("pointer increment wrong");

  c_long_write_done: cover property (core_halt ##1 !core_halt);
  c_ext_write: cover property ($fell(bus_wr_n));
  c_ext_read: cover property ($fell(bus_oe_n));
  c_abort: cover property ($rose(aborted));

endmodule
`default_nettype wire

// *** verif/pmt_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// Program memory on the far side: internal store with one-clock registered
// reads, and an external store on the multiplexed bus.
module pmt_mem_model (
  input wire logic pclk,
  input wire logic [15:0] prog_addr,
  input wire logic [15:0] prog_wdata,
  input wire logic prog_write,
  input wire logic prog_read,
  output logic [15:0] prog_rdata,
  input wire logic [15:0] bus_out,
  input wire logic bus_ale,
  input wire logic bus_oe_n,
  input wire logic bus_wr_n,
  output logic [15:0] bus_in
);
  logic [15:0] int_mem [logic [15:0]];
  logic [15:0] ext_mem [logic [15:0]];
  logic [15:0] ext_addr;
  logic [1:0] hold;

  function automatic logic [15:0] fill(input logic [15:0] a, input logic ext);
    return ext ? (a ^ 16'hc3a5) : (a ^ 16'h5a3c);
  endfunction

  initial begin
    prog_rdata = 16'h0000;
    bus_in = 16'h0000;
    ext_addr = 16'h0000;
    hold = 2'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data stands for three clocks, then turns to junk every clock.
  always @(posedge pclk) begin
    if (prog_read) begin
      prog_rdata <= int_mem.exists(prog_addr) ? int_mem[prog_addr]
                                              : fill(prog_addr, 1'b0);
      hold <= 2'h2;
    end else if (hold != 2'h0) begin
      hold <= hold - 2'h1;
    end else begin
      prog_rdata <= ~prog_rdata;
    end
    if (prog_write) begin
      int_mem[prog_addr] = prog_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The external bus returns memory data only while its output enable is low, and toggling junk otherwise.
  always @(posedge pclk) begin
    if (bus_ale) begin
      ext_addr = bus_out;
    end
    if (!bus_wr_n) begin
      ext_mem[ext_addr] = bus_out;
    end
    if (!bus_oe_n) begin
      bus_in <= ext_mem.exists(ext_addr) ? ext_mem[ext_addr]
                                         : fill(ext_addr, 1'b1);
    end else begin
      bus_in <= ~bus_in;
    end
  end
endmodule

`default_nettype wire

// *** verif/program_memory_table_access_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pmt_regs.svh"

module program_memory_table_access_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed, rd;
  logic ext_mode, prog_volt, glob_dis, vector_req, core_halt, err;
  logic [3:0] irq_enable, irq_flag;
  logic [2:0] irq_flag_clear, clr_seen;
  logic prog_write, prog_read, bus_drive_n, bus_ale, bus_oe_n, bus_wr_n;
  logic [15:0] prog_addr, prog_wdata, prog_rdata, bus_out, bus_in;
  logic mon_clr, halt_seen;
  int fails, n_compared, vec_cnt;

  pmt_table_access dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_mode(ext_mode), .clear_and_prog_voltage_pin(prog_volt),
    .global_interrupt_disable(glob_dis), .irq_enable(irq_enable),
    .irq_flag(irq_flag), .irq_flag_clear(irq_flag_clear),
    .vector_req(vector_req), .core_halt(core_halt),
    .prog_addr(prog_addr), .prog_wdata(prog_wdata),
    .prog_write(prog_write), .prog_read(prog_read),
    .prog_rdata(prog_rdata), .muxed_addr_data_bus_out(bus_out),
    .muxed_addr_data_bus_in(bus_in), .muxed_addr_data_bus_oe_n(bus_drive_n),
    .bus_ale(bus_ale), .bus_oe_n(bus_oe_n), .bus_wr_n(bus_wr_n));

  pmt_mem_model mem (.pclk(pclk), .prog_addr(prog_addr),
    .prog_wdata(prog_wdata), .prog_write(prog_write),
    .prog_read(prog_read), .prog_rdata(prog_rdata), .bus_out(bus_out),
    .bus_ale(bus_ale), .bus_oe_n(bus_oe_n), .bus_wr_n(bus_wr_n),
    .bus_in(bus_in));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (mon_clr) begin
      clr_seen <= 3'h0;
      vec_cnt <= 0;
      halt_seen <= 1'b0;
    end else begin
      clr_seen <= clr_seen | irq_flag_clear;
      vec_cnt <= vec_cnt + int'(vector_req);
      halt_seen <= halt_seen | core_halt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  function automatic logic [15:0] efill(input logic [15:0] a, input logic e);
    return e ? (a ^ 16'hc3a5) : (a ^ 16'h5a3c);
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) fails++;
  endtask

  // Issues one operation and polls the busy bit until it is idle again.
  task automatic run(input pmt_pkg::pmt_op_t o, input logic hi,
                     input logic inc, input logic [7:0] b);
    int n;
    apb(1'b1, `PMT_OFS_CMD, {16'h0, b, 4'h0, inc, hi, o});
    n = 0;
    do begin
      apb(1'b0, `PMT_OFS_STAT, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 40);
  endtask

  task automatic rd_data(input logic hi, input logic [7:0] exp);
    run(pmt_pkg::latch_read_op, hi, 1'b0, 8'h00);
    apb(1'b0, `PMT_OFS_DATA, 32'h0);
    chk(rd, {24'h0, exp});
  endtask

  task automatic mon_reset;
    @(posedge pclk);
    mon_clr <= 1'b1;
    @(posedge pclk);
    mon_clr <= 1'b0;
  endtask

  task automatic halt_wait(input logic lvl);
    int n;
    n = 0;
    while (core_halt !== lvl && n < 60) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, core_halt}, {31'h0, lvl});
  endtask

  initial begin
    repeat (50000) @(posedge pclk);
    fails++;
    end_sim;
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] a, w, e;
    int s, g;
    {presetn, psel, penable, pwrite, ext_mode, glob_dis, mon_clr} = 7'h0;
    {paddr, pwdata, irq_enable, irq_flag} = '0;
    prog_volt = 1'b1;
    seed = 32'd30;
    fails = 0;
    n_compared = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `PMT_OFS_PTR, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, err}, 32'h1);
    for (int k = 0; k < 8; k++) begin
      s = k % 4;
      g = k / 4;
      seed = xs(seed);
      {w, a} = seed;
      glob_dis <= g[0];
      apb(1'b1, `PMT_OFS_PTR, {16'h0, a});
      run(pmt_pkg::latch_write_op, 1'b1, 1'b0, w[15:8]);
      mon_reset;
      apb(1'b1, `PMT_OFS_CMD, {16'h0, w[7:0], 4'h0, 2'h2, 2'h2});
      halt_wait(1'b1);
      chk({prog_addr, prog_wdata}, {a, w});
      irq_enable <= 4'hf ^ (4'h1 << s);
      irq_flag <= 4'h1 << s;
      repeat (30) @(posedge pclk);
      chk({31'h0, core_halt}, 32'h1);
      irq_enable <= 4'h1 << s;
      halt_wait(1'b0);
      repeat (3) @(posedge pclk);
      chk({29'h0, clr_seen}, (s < 3) ? (32'h1 << s) : 32'h0);
      chk(vec_cnt, {31'h0, ~g[0]});
      irq_enable <= 4'h0;
      irq_flag <= 4'h0;
      apb(1'b0, `PMT_OFS_PTR, 32'h0);
      chk(rd, {16'h0, a + 16'h1});
      e = efill(a + 16'h2, 1'b0);
      apb(1'b1, `PMT_OFS_PTR, {16'h0, a + 16'h2});
      run(pmt_pkg::table_read_op, 1'b0, 1'b0, 8'h00);
      apb(1'b1, `PMT_OFS_PTR, {16'h0, a});
      run(pmt_pkg::table_read_op, 1'b1, 1'b1, 8'h00);
      apb(1'b0, `PMT_OFS_DATA, 32'h0);
      chk(rd, {24'h0, e[15:8]});
      rd_data(1'b1, w[15:8]);
      rd_data(1'b0, w[7:0]);
    end
    irq_enable <= 4'he;
    irq_flag <= 4'he;
    mon_reset;
    apb(1'b1, `PMT_OFS_PTR, {16'h0, a});
    run(pmt_pkg::table_write_op, 1'b0, 1'b1, 8'h5a);
    chk({28'h0, clr_seen, halt_seen}, 32'h4);
    apb(1'b0, `PMT_OFS_STAT, 32'h0);
    chk({31'h0, rd[2]}, 32'h1);
    irq_enable <= 4'h0;
    irq_flag <= 4'h0;
    prog_volt <= 1'b0;
    repeat (8) @(posedge pclk);
    seed = xs(seed);
    a = seed[15:0];
    mon_reset;
    apb(1'b1, `PMT_OFS_PTR, {16'h0, a});
    run(pmt_pkg::table_write_op, 1'b0, 1'b0, 8'h77);
    chk({31'h0, halt_seen}, 32'h0);
    e = efill(a, 1'b0);
    run(pmt_pkg::table_read_op, 1'b0, 1'b0, 8'h00);
    rd_data(1'b0, e[7:0]);
    prog_volt <= 1'b1;
    ext_mode <= 1'b1;
    seed = xs(seed);
    {w, a} = seed;
    mon_reset;
    apb(1'b1, `PMT_OFS_PTR, {16'h0, a});
    run(pmt_pkg::latch_write_op, 1'b1, 1'b0, w[15:8]);
    run(pmt_pkg::table_write_op, 1'b0, 1'b0, w[7:0]);
    apb(1'b1, `PMT_OFS_PTR, {16'h0, a + 16'h1});
    run(pmt_pkg::table_read_op, 1'b0, 1'b0, 8'h00);
    run(pmt_pkg::table_write_op, 1'b0, 1'b0, 8'h3c);
    apb(1'b1, `PMT_OFS_PTR, {16'h0, a});
    run(pmt_pkg::table_read_op, 1'b0, 1'b1, 8'h00);
    rd_data(1'b1, w[15:8]);
    rd_data(1'b0, w[7:0]);
    run(pmt_pkg::table_read_op, 1'b0, 1'b0, 8'h00);
    rd_data(1'b1, w[15:8]);
    rd_data(1'b0, 8'h3c);
    apb(1'b0, `PMT_OFS_STAT, 32'h0);
    chk({30'h0, rd[3], halt_seen}, 32'h2);
    end_sim;
  end
endmodule

`default_nettype wire
